// File: erf_consts.svh
// Constants for the receive frame filter: offsets, fields, reset values.
// Behaviour
// - Eight filter rows, each enabled alone, checked against every frame.
// - A frame passes when one enabled row fully matches; AND then OR.
// - A row selects comparisons; each holds a value and an optional mask.
// - With mask enabled only bits whose mask bit is one are compared.
// - Pattern offset counts bytes from the first destination MAC byte.
// - Three encapsulation allow bits: type-field, SNAP and LLC frames.
// - With no allow bit set every encapsulation is admitted.
// - While follow is set, port two copies every port one control and row write.
// - Pattern matches a 32-bit value in four consecutive frame bytes.
// - One pattern offset serves all rows, used only in enabled rows.
// - MPLS and VLAN comparisons check only the outermost level, one tag word.
`ifndef ERF_CONSTS_SVH
`define ERF_CONSTS_SVH

// ****************************************************************
// Register map (byte addresses).
// ****************************************************************
`define ERF_A_CTRL       12'h000
`define ERF_A_STATUS     12'h004
`define ERF_A_POFF       12'h008
`define ERF_A_P2_CTRL    12'h00c
`define ERF_A_ROW_BASE   12'h100
`define ERF_ROW_STRIDE   12'h040
// Word index inside a row block.
`define ERF_W_SEL        4'h0
`define ERF_W_MSKEN      4'h1
`define ERF_W_DMAC_LO    4'h2
`define ERF_W_DMAC_HI    4'h3
`define ERF_W_DMSK_LO    4'h4
`define ERF_W_DMSK_HI    4'h5
`define ERF_W_SMAC_LO    4'h6
`define ERF_W_SMAC_HI    4'h7
`define ERF_W_SMSK_LO    4'h8
`define ERF_W_SMSK_HI    4'h9
`define ERF_W_PAT        4'ha
`define ERF_W_PMSK       4'hb
`define ERF_W_VLAN       4'hc
`define ERF_W_VMSK       4'hd
`define ERF_W_MPLS       4'he
`define ERF_W_MMSK       4'hf

// ****************************************************************
// Field positions.
// ****************************************************************
`define ERF_C_FILT_EN    0
`define ERF_C_ALLOW_ETH  1
`define ERF_C_ALLOW_SNAP 2
`define ERF_C_ALLOW_LLC  3
`define ERF_C_FOLLOW     4
`define ERF_F_DMAC       0
`define ERF_F_SMAC       1
`define ERF_F_PAT        2
`define ERF_F_VLAN       3
`define ERF_F_MPLS       4
`define ERF_NFIELD       5
`define ERF_CTRL_RST     32'h0000_0000
`define ERF_ETYPE_MIN    16'h0600
`define ERF_LLC_SNAP     16'haaaa
`define ERF_ETH_VLAN     16'h8100
`define ERF_ETH_MPLS     16'h8847
`define ERF_HDR_MAX      8'hff

`endif

// File: erf_pkg.sv
// Types shared by the receive frame filter.
package erf_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } erf_beat_t;

    typedef struct packed {
        logic [4:0]  sel;
        logic [4:0]  msken;
        logic [47:0] dmac;
        logic [47:0] dmsk;
        logic [47:0] smac;
        logic [47:0] smsk;
        logic [31:0] pat;
        logic [31:0] pmsk;
        logic [31:0] vlan;
        logic [31:0] vmsk;
        logic [31:0] mpls;
        logic [31:0] mmsk;
    } erf_row_t;

    typedef enum logic [1:0] {
        ERF_IDLE,
        ERF_HDR,
        ERF_DRAIN
    } erf_state_t;
endpackage

// File: erf_fifo.sv
// Frame byte FIFO in front of the filter.
`timescale 1ns/1ps
module erf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,   // Clock.
    input  wire logic             rst_i,   // Synchronous reset.
    input  wire logic [WIDTH-1:0] wdata_i, // Write data.
    input  wire logic             wvalid_i,// Write valid.
    output      logic             wready_o,// Not full.
    output      logic [WIDTH-1:0] rdata_o, // Head data.
    output      logic             rvalid_o,// Not empty.
    input  wire logic             rready_i // Pop.
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("erf_fifo: DEPTH must be a power of two");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              push = wvalid_i && wready_o;
    wire              pop  = rvalid_o && rready_i;

    // Full when pointers differ only in the wrap bit.
    assign wready_o = !((wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign rvalid_o = (wp_q != rp_q);
    assign rdata_o  = mem_q[rp_q[AW-1:0]];

    // Pointer update.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
        end
    end

    // Storage has no reset; empty state hides stale words.
    always_ff @(posedge clk_i) begin
        if (push) mem_q[wp_q[AW-1:0]] <= wdata_i;
    end
endmodule

// File: erf_filter.sv
// Receive frame filter: row matching, encapsulation check and registers.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "erf_consts.svh"
module erf_filter
    import erf_pkg::*;
#(
    parameter int NROWS = 8,
    parameter int DEPTH = 32
) (
    input  wire logic        clk_i,      // 200 MHz clock.
    input  wire logic        rst_i,      // Synchronous reset, high.
    // Wishbone classic slave.
    input  wire logic        wb_cyc_i,   // Cycle.
    input  wire logic        wb_stb_i,   // Strobe.
    input  wire logic        wb_we_i,    // Write enable.
    input  wire logic [11:0] wb_adr_i,   // Byte address.
    input  wire logic [3:0]  wb_sel_i,   // Byte lanes.
    input  wire logic [31:0] wb_dat_i,   // Write data.
    output      logic [31:0] wb_dat_o,   // Read data.
    output      logic        wb_ack_o,   // Acknowledge.
    // Receive byte stream from the MAC.
    input  wire logic [7:0]  rx_data_i,  // Frame byte.
    input  wire logic        rx_last_i,  // Last byte.
    input  wire logic        rx_valid_i, // Byte valid.
    output      logic        rx_ready_o, // FIFO has room.
    // Verdict per frame.
    output      logic        vd_valid_o, // Verdict pulse.
    output      logic        vd_pass_o,  // Frame forwarded.
    // Mirror of the second port's filter state.
    output      logic [31:0] p2_ctrl_o   // Port two control.
);
    initial begin
        if (NROWS != 8) $error("erf_filter: NROWS must be 8");
    end

    // ****************************************************************
    // Buffering.
    // ****************************************************************
    erf_beat_t in_beat;
    erf_beat_t hd_beat;
    logic      hd_valid;
    assign in_beat.data = rx_data_i;
    assign in_beat.last = rx_last_i;
    erf_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wdata_i  (in_beat),
        .wvalid_i (rx_valid_i),
        .wready_o (rx_ready_o),
        .rdata_o  (hd_beat),
        .rvalid_o (hd_valid),
        .rready_i (1'b1)
    );
    // The filter consumes one byte a cycle; the FIFO absorbs bus bursts.
    wire take = hd_valid;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [7:0]  poff_q;
    logic [31:0] p2_ctrl_q;
    logic [31:0] rowmem_q [NROWS*16];
    logic [31:0] p2mem_q [NROWS*16];
    logic [31:0] fr_cnt_q;
    logic [31:0] pass_cnt_q;
    logic        ack_q;

    wire req      = wb_cyc_i && wb_stb_i && !ack_q;
    wire row_hit  = wb_adr_i >= `ERF_A_ROW_BASE &&
                    wb_adr_i < (`ERF_A_ROW_BASE + 12'h200);
    // Offset into the row area; raw address bits would rotate the table.
    wire [11:0] roff = wb_adr_i - `ERF_A_ROW_BASE;
    wire [6:0] ridx = roff[8:2];
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr = req && wb_we_i;
    wire follow = ctrl_q[`ERF_C_FOLLOW];

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [31:0] m);
        merge = (o & ~m) | (n & m);
    endfunction

    // Port two takes the very word port one gets, so the copy cannot drift.
    wire [31:0] ctrl_d = merge(ctrl_q, wb_dat_i, bmask);
    wire [31:0] row_d  = merge(rowmem_q[ridx], wb_dat_i, bmask);

    // Control words; port two takes every port one control write while following.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q    <= `ERF_CTRL_RST;
            poff_q    <= 8'h00;
            p2_ctrl_q <= `ERF_CTRL_RST;
        end else if (wr) begin
            if (wb_adr_i == `ERF_A_CTRL) begin
                ctrl_q <= ctrl_d;
                if (follow) begin
                    p2_ctrl_q <= ctrl_d;
                end
            end else if (wb_adr_i == `ERF_A_POFF && wb_sel_i[0]) begin
                poff_q <= wb_dat_i[7:0];
            end else if (wb_adr_i == `ERF_A_P2_CTRL && !follow) begin
                p2_ctrl_q <= merge(p2_ctrl_q, wb_dat_i, bmask);
            end
        end
    end

    // Row table, with the mirrored copy for port two.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NROWS*16; i++) begin
                rowmem_q[i] <= 32'h0;
                p2mem_q[i]  <= 32'h0;
            end
        end else if (wr && row_hit) begin
            rowmem_q[ridx] <= row_d;
            if (follow) begin
                p2mem_q[ridx] <= row_d;
            end
        end
    end

    // Read decode; unmapped addresses read zero and still acknowledge.
    wire [31:0] rd_val =
        (wb_adr_i == `ERF_A_CTRL)    ? ctrl_q :
        (wb_adr_i == `ERF_A_STATUS)  ? pass_cnt_q :
        (wb_adr_i == `ERF_A_POFF)    ? {24'h0, poff_q} :
        (wb_adr_i == `ERF_A_P2_CTRL) ? p2_ctrl_q :
        row_hit                      ? rowmem_q[ridx] : 32'h0;

    // Single registered acknowledge one cycle after the request, dropped the next cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q    <= req;
            wb_dat_o <= req ? rd_val : 32'h0;
        end
    end
    assign wb_ack_o  = ack_q;
    assign p2_ctrl_o = p2_ctrl_q;

    // ****************************************************************
    // Header capture.
    // ****************************************************************
    erf_state_t  st_q;
    logic [7:0]  pos_q;
    logic [47:0] dmac_q;
    logic [47:0] smac_q;
    logic [15:0] etype_q;
    logic [15:0] llc_q;
    logic [31:0] pat_q;
    logic [31:0] tag_q;
    wire  [7:0]  b = hd_beat.data;

    // Byte position counter and field shifters.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q  <= ERF_IDLE;
            pos_q <= 8'h00;
        end else if (take) begin
            pos_q <= hd_beat.last ? 8'h00 :
                     (pos_q == `ERF_HDR_MAX) ? pos_q : pos_q + 8'h01;
            st_q  <= hd_beat.last ? ERF_IDLE : ERF_HDR;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dmac_q  <= '0;
            smac_q  <= '0;
            etype_q <= '0;
            llc_q   <= '0;
            pat_q   <= '0;
            tag_q   <= '0;
        end else if (take) begin
            if (pos_q < 8'd6) dmac_q <= {dmac_q[39:0], b};
            else if (pos_q < 8'd12) smac_q <= {smac_q[39:0], b};
            else if (pos_q < 8'd14) etype_q <= {etype_q[7:0], b};
            else if (pos_q < 8'd16) llc_q <= {llc_q[7:0], b};
            if (pos_q >= 8'd14 && pos_q < 8'd18) tag_q <= {tag_q[23:0], b};
            if (pos_q >= poff_q && pos_q < poff_q + 8'd4)
                pat_q <= {pat_q[23:0], b};
        end
    end

    // ****************************************************************
    // Matching.
    // ****************************************************************
    function automatic logic fmatch(input logic [47:0] v,
                                    input logic [47:0] r,
                                    input logic [47:0] m,
                                    input logic        me);
        fmatch = me ? (((v ^ r) & m) == 48'h0) : (v == r);
    endfunction

    wire is_vlan = etype_q == `ERF_ETH_VLAN;
    wire is_mpls = etype_q == `ERF_ETH_MPLS;
    logic [NROWS-1:0] row_ok;
    logic [NROWS-1:0] row_en;

    genvar g;
    generate
        for (g = 0; g < NROWS; g++) begin : g_row
            wire [31:0] w [16];
            for (genvar k = 0; k < 16; k++) begin : g_w
                assign w[k] = rowmem_q[g*16+k];
            end
            wire [4:0] sel = w[`ERF_W_SEL][4:0];
            wire [4:0] me  = w[`ERF_W_MSKEN][4:0];
            wire [`ERF_NFIELD-1:0] hit;
            assign row_en[g] = w[`ERF_W_SEL][31];
            assign hit[`ERF_F_DMAC] = fmatch(dmac_q,
                {w[`ERF_W_DMAC_HI][15:0], w[`ERF_W_DMAC_LO]},
                {w[`ERF_W_DMSK_HI][15:0], w[`ERF_W_DMSK_LO]},
                me[`ERF_F_DMAC]);
            assign hit[`ERF_F_SMAC] = fmatch(smac_q,
                {w[`ERF_W_SMAC_HI][15:0], w[`ERF_W_SMAC_LO]},
                {w[`ERF_W_SMSK_HI][15:0], w[`ERF_W_SMSK_LO]},
                me[`ERF_F_SMAC]);
            assign hit[`ERF_F_PAT] = fmatch({16'h0, pat_q},
                {16'h0, w[`ERF_W_PAT]}, {16'h0, w[`ERF_W_PMSK]},
                me[`ERF_F_PAT]);
            // Only the outermost stacked level is compared here.
            assign hit[`ERF_F_VLAN] = is_vlan &&
                fmatch({16'h0, tag_q},
                {16'h0, w[`ERF_W_VLAN]}, {16'h0, w[`ERF_W_VMSK]},
                me[`ERF_F_VLAN]);
            assign hit[`ERF_F_MPLS] = is_mpls &&
                fmatch({16'h0, tag_q},
                {16'h0, w[`ERF_W_MPLS]}, {16'h0, w[`ERF_W_MMSK]},
                me[`ERF_F_MPLS]);
            // Unselected fields count as hits; AND runs over the chosen set.
            assign row_ok[g] = row_en[g] &&
                ((hit | ~sel) == 5'h1f);
        end
    endgenerate

    // ****************************************************************
    // Encapsulation and verdict.
    // ****************************************************************
    wire typed  = etype_q >= `ERF_ETYPE_MIN;
    wire snap   = !typed && llc_q == `ERF_LLC_SNAP;
    wire llc    = !typed && !snap;
    wire [2:0] allow = ctrl_q[`ERF_C_ALLOW_LLC:`ERF_C_ALLOW_ETH];
    wire encap_ok = (allow == 3'b000) ||
                    (allow[0] && typed) || (allow[1] && snap) ||
                    (allow[2] && llc);
    wire any_row = |row_ok;
    wire pass = !ctrl_q[`ERF_C_FILT_EN] || (any_row && encap_ok);

    // Verdict two cycles after the last byte; fields are complete when fin_q is set.
    logic fin_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fin_q      <= 1'b0;
            vd_valid_o <= 1'b0;
            vd_pass_o  <= 1'b0;
            fr_cnt_q   <= 32'h0;
            pass_cnt_q <= 32'h0;
        end else begin
            fin_q      <= take && hd_beat.last;
            vd_valid_o <= fin_q;
            vd_pass_o  <= fin_q ? pass : 1'b0;
            if (fin_q) fr_cnt_q <= fr_cnt_q + 32'h1;
            if (fin_q && pass) pass_cnt_q <= pass_cnt_q + 32'h1;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_filter_off_pass: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (fin_q && !ctrl_q[`ERF_C_FILT_EN]) |=> vd_valid_o && vd_pass_o)
        else $error("disabled filter dropped a frame");
    a_no_row_drop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (fin_q && ctrl_q[`ERF_C_FILT_EN] && row_en == '0) |=> !vd_pass_o)
        else $error("frame passed with no enabled row");
    a_encap_block: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (fin_q && ctrl_q[`ERF_C_FILT_EN] && !encap_ok) |=> !vd_pass_o)
        else $error("frame passed with forbidden encapsulation");
    a_encap_open: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (fin_q && ctrl_q[`ERF_C_FILT_EN] && allow == 3'b000 && any_row)
        |=> vd_pass_o)
        else $error("open encapsulation dropped a matching frame");
    a_follow_copy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr && follow && wb_adr_i == `ERF_A_CTRL) |=> p2_ctrl_q == ctrl_q)
        else $error("port two missed a control write");
    a_row_pass: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (fin_q && ctrl_q[`ERF_C_FILT_EN] && any_row && encap_ok)
        |=> vd_valid_o && vd_pass_o)
        else $error("matching frame was dropped");
    a_verdict_once: assert property (
        @(posedge clk_i) disable iff (rst_i)
        vd_valid_o |=> !vd_valid_o)
        else $error("verdict held more than one cycle");
    a_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("register access not acknowledged once");
    // The offset only means something if every frame restarts at byte zero.
    a_pass_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pass_cnt_q <= fr_cnt_q)
        else $error("more passed frames than frames seen");
    a_hdr_start: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (take && st_q == ERF_IDLE) |-> pos_q == 8'h00)
        else $error("frame did not start at byte zero");
    a_follow_rows: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr && row_hit && follow)
        |=> p2mem_q[$past(ridx)] == rowmem_q[$past(ridx)])
        else $error("port two missed a row write");
endmodule

// File: erf_mac_model.sv
// Model of the receive MAC path that feeds frame bytes to the filter.
`timescale 1ns/1ps
module erf_mac_model
    import erf_pkg::*;
(
    input  wire logic       clk_i,      // Clock.
    input  wire logic       rst_i,      // Synchronous reset, high.
    input  wire logic       slow_i,     // Insert random idle gaps.
    input  wire logic       rx_ready_i, // Filter can take a byte.
    output      logic [7:0] rx_data_o,  // Frame byte.
    output      logic       rx_last_o,  // Last byte of a frame.
    output      logic       rx_valid_o  // Byte valid.
);
    erf_beat_t beat_q[$];

    // Queues a whole frame; the destination MAC goes out first.
    task automatic push_frame(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            beat_q.push_back('{data: b[i], last: (i == b.size() - 1)});
        end
    endtask

    // A byte is held until taken. Between bytes the data lines toggle, so
    // a filter that samples without valid sees garbage, not a stale byte.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_o <= 1'b0;
            rx_last_o  <= 1'b0;
            rx_data_o  <= 8'h00;
        end else if (!rx_valid_o || rx_ready_i) begin
            if (beat_q.size() > 0 && !(slow_i && $urandom_range(1) == 1)) begin
                {rx_data_o, rx_last_o} <= beat_q.pop_front();
                rx_valid_o <= 1'b1;
            end else begin
                rx_valid_o <= 1'b0;
                rx_last_o  <= 1'b0;
                rx_data_o  <= ~rx_data_o;
            end
        end
    end
endmodule

// File: testbench.sv
// Self-checking bench for the receive frame filter.
`timescale 1ns/1ps
`include "erf_consts.svh"
module testbench;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [11:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic [7:0]  rx_data;
    logic        rx_last;
    logic        rx_valid;
    logic        rx_ready;
    logic        vd_valid;
    logic        vd_pass;
    logic [31:0] p2_ctrl;
    logic        slow;
    logic [47:0] d;
    logic [47:0] s;
    logic [31:0] p;
    logic [7:0]  fr[$];
    logic [31:0] exp_vd[$];
    logic [31:0] exp_rd[$];
    int          n_fail;
    int          n_compared;
    int          n_pass;

    erf_filter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .rx_data_i(rx_data), .rx_last_i(rx_last),
        .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
        .vd_valid_o(vd_valid), .vd_pass_o(vd_pass), .p2_ctrl_o(p2_ctrl));

    erf_mac_model u_mac (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_last_o(rx_last),
        .rx_valid_o(rx_valid));

    // ****************************************************************
    // Checking and closing.
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Each result that shows up takes the oldest note off its queue.
    always @(posedge clk_i) begin
        if (vd_valid === 1'b1) begin
            chk({31'h0, vd_pass}, exp_vd.size() ? exp_vd.pop_front() : 32'hx);
        end
        if (wb_ack === 1'b1 && wb_we === 1'b0) begin
            chk(wb_rdat, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
        end
    end

    // ****************************************************************
    // Bus and frame tasks.
    // ****************************************************************
    // One classic cycle; only the watchdog ends a wait for acknowledge.
    task automatic wb_cycle(input logic w, input logic [11:0] a,
                            input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_adr  <= a;
        wb_wdat <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        wb_cycle(1'b0, a, 32'h0);
    endtask

    task automatic row_wr(input int r, input logic [3:0] w,
                          input logic [31:0] dat);
        wb_cycle(1'b1, `ERF_A_ROW_BASE + 12'(r) * `ERF_ROW_STRIDE
                 + {6'h0, w, 2'b00}, dat);
    endtask

    // Frame: destination, source, type or length, one word, four fill bytes.
    task automatic build(input logic [47:0] dm, input logic [47:0] sm,
                         input logic [15:0] t, input logic [31:0] pw);
        fr = {};
        for (int i = 5; i >= 0; i--) fr.push_back(dm[i*8 +: 8]);
        for (int i = 5; i >= 0; i--) fr.push_back(sm[i*8 +: 8]);
        fr.push_back(t[15:8]);
        fr.push_back(t[7:0]);
        for (int i = 3; i >= 0; i--) fr.push_back(pw[i*8 +: 8]);
        for (int i = 0; i < 4; i++) fr.push_back(8'($urandom));
    endtask

    task automatic send(input logic pass);
        exp_vd.push_back({31'h0, pass});
        if (pass) n_pass++;
        u_mac.push_frame(fr);
    endtask

    // Config changes wait until every frame in flight has its verdict.
    task automatic drain();
        int k;
        k = 0;
        while (exp_vd.size() > 0 && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        chk(32'(exp_vd.size()), 32'h0);
        repeat (4) @(posedge clk_i);
    endtask

    // ****************************************************************
    // Clock, watchdog and scenarios.
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // Budget of 80000 cycles is tens of times the few thousand cycles the tests need.
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end

    initial begin
        {wb_cyc, wb_stb, wb_we, slow} = 4'h0;
        wb_adr = 12'h000;
        wb_sel = 4'hf;
        wb_wdat = 32'h0;
        rst_i = 1'b1;
        void'($urandom(10));
        d = {16'($urandom), $urandom};
        s = {16'($urandom), $urandom};
        p = $urandom;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`ERF_A_CTRL, `ERF_CTRL_RST);
        rd(`ERF_A_STATUS, 32'h0);
        wb_cycle(1'b1, 12'h010, 32'hffff_ffff);
        rd(12'h010, 32'h0);
        build(d, s, 16'h0800, p);
        send(1'b1);
        slow <= 1'b1;
        send(1'b1);
        drain();
        wb_cycle(1'b1, `ERF_A_CTRL, 32'h1);
        send(1'b0);
        drain();
        row_wr(3, `ERF_W_DMAC_LO, d[31:0]);
        row_wr(3, `ERF_W_DMAC_HI, {16'h0, d[47:32]});
        row_wr(3, `ERF_W_SEL, 32'h8000_0001);
        send(1'b1);
        build(d ^ 48'h1, s, 16'h0800, p);
        send(1'b0);
        drain();
        row_wr(3, `ERF_W_SMAC_LO, s[31:0]);
        row_wr(3, `ERF_W_SMAC_HI, {16'h0, s[47:32]});
        row_wr(3, `ERF_W_SEL, 32'h8000_0003);
        build(d, s ^ 48'h1, 16'h0800, p);
        send(1'b0);
        drain();
        row_wr(5, `ERF_W_SMAC_LO, s[31:0] ^ 32'h1);
        row_wr(5, `ERF_W_SMAC_HI, {16'h0, s[47:32]});
        row_wr(5, `ERF_W_SEL, 32'h8000_0002);
        send(1'b1);
        drain();
        row_wr(3, `ERF_W_SEL, 32'h0);
        row_wr(5, `ERF_W_SEL, 32'h0);
        row_wr(2, `ERF_W_DMAC_LO, d[31:0]);
        row_wr(2, `ERF_W_DMAC_HI, {16'h0, d[47:32]});
        row_wr(2, `ERF_W_DMSK_LO, 32'h00ff_ffff);
        row_wr(2, `ERF_W_DMSK_HI, 32'h0000_00ff);
        row_wr(2, `ERF_W_MSKEN, 32'h1);
        row_wr(2, `ERF_W_SEL, 32'h8000_0001);
        build(d ^ 48'hff00_0000_0000, s, 16'h0800, p);
        send(1'b1);
        build(d ^ 48'h0000_0100_0000, s, 16'h0800, p);
        send(1'b1);
        build(d ^ 48'h0000_0001_0000, s, 16'h0800, p);
        send(1'b0);
        drain();
        row_wr(2, `ERF_W_SEL, 32'h0);
        wb_cycle(1'b1, `ERF_A_POFF, 32'h7);
        row_wr(4, `ERF_W_PAT, s[39:8]);
        row_wr(4, `ERF_W_SEL, 32'h0000_0004);
        build(d, s, 16'h0800, p);
        send(1'b0);
        drain();
        row_wr(4, `ERF_W_SEL, 32'h8000_0004);
        send(1'b1);
        drain();
        wb_cycle(1'b1, `ERF_A_POFF, 32'h8);
        send(1'b0);
        drain();
        row_wr(4, `ERF_W_SEL, 32'h0);
        row_wr(1, `ERF_W_VLAN, p);
        row_wr(1, `ERF_W_SEL, 32'h8000_0008);
        build(d, s, 16'h8100, p);
        send(1'b1);
        build(d, s, 16'h8100, p ^ 32'h0001_0000);
        send(1'b0);
        drain();
        row_wr(1, `ERF_W_MPLS, p);
        row_wr(1, `ERF_W_MMSK, 32'hffff_f000);
        row_wr(1, `ERF_W_MSKEN, 32'h10);
        row_wr(1, `ERF_W_SEL, 32'h8000_0010);
        build(d, s, 16'h8847, p ^ 32'h0000_0fff);
        send(1'b1);
        build(d, s, 16'h8847, p ^ 32'h0010_0000);
        send(1'b0);
        drain();
        row_wr(1, `ERF_W_SEL, 32'h0);
        row_wr(0, `ERF_W_SEL, 32'h8000_0000);
        // Every allow setting against type, SNAP and LLC frames.
        for (int a = 0; a < 8; a++) begin
            wb_cycle(1'b1, `ERF_A_CTRL, {28'h0, 3'(a), 1'b1});
            build(d, s, 16'h0800, p);
            send(a == 0 || a[0]);
            build(d, s, 16'h0040, 32'haaaa_0300);
            send(a == 0 || a[1]);
            build(d, s, 16'h0040, 32'h4242_0300);
            send(a == 0 || a[2]);
            drain();
        end
        rd(`ERF_A_STATUS, 32'(n_pass));
        wb_cycle(1'b1, `ERF_A_CTRL, 32'h0);
        wb_cycle(1'b1, `ERF_A_P2_CTRL, 32'h0000_000e);
        @(posedge clk_i);
        chk(p2_ctrl, 32'h0000_000e);
        wb_cycle(1'b1, `ERF_A_CTRL, 32'h11);
        wb_cycle(1'b1, `ERF_A_CTRL, 32'h1d);
        @(posedge clk_i);
        chk(p2_ctrl, 32'h0000_001d);
        wb_cycle(1'b1, `ERF_A_P2_CTRL, 32'h3);
        row_wr(6, `ERF_W_PAT, p);
        @(posedge clk_i);
        chk(p2_ctrl, 32'h0000_001d);
        print_verdict();
    end
endmodule
